// ---- hw/sensor_scan_sequencer.sv ----
// Channel scan sequencer: slot phases, excitation, processing, alarms,
// result posting and host command answers.
// Assumes converter done and host command inputs are asynchronous pins.
`timescale 1ns/1ps

// Overview of operation
// - Slot start picks next channel and switches sense and excitation mux.
// - Passive sensor channels get excitation turned on before settling.
// - Conversion starts after settling; processing runs after conversion, during recovery.
// - Converted raw value goes to processing tagged with its channel.
// - Processing overlaps the recover phase, slot unaffected.
// - Normalise and scale, then single-pole low-pass filter.
// - Limit violation disables channel alarm and sets global alarm flag.
// - Finished value is written last into dual-port result memory.
// - Host commands are served first, as soon as they pass the two-flop synchroniser.
// - Each slot has setup-settle, digitize and recover phases.
// - Recover phase resets the analog front end.
// - High-speed mode shortens only the digitize phase.
// - Excitation stays on for the whole slot of a passive sensor.
// - Excitation source chosen from sensor kind: 10 V, current, 5 V series.
// - At most one reference measurement per sixteen channel measurements.
// - Disabled channels are skipped and take no slot.
// - Host servicing pauses scanning and lengthens the current slot.
// - Single read answered in 100 us, all-channel read in 130 us.
// - Default-mode slot lasts at most 22 ms.
// - A violated limit returns to its disabled default.
module sensor_scan_sequencer
   import scan_pkg::*;
#(
   parameter int SETTLE_CYCLES  = SETTLE_CYC,
   parameter int CONV_CYCLES    = CONV_CYC,
   parameter int CONV_HS_CYCLES = CONV_HS_CYC,
   parameter int RECOVER_CYCLES = RECOVER_CYC,
   parameter int ONE_RSP_CYCLES = ONE_RSP_CYC,
   parameter int ALL_RSP_CYCLES = ALL_RSP_CYC
)
(
   // Clock and reset
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst,
   // Mode
   input  wire logic                     i_high_speed,
   // Converter
   input  wire logic                     i_adc_done,
   input  wire logic [scan_pkg::DATA_W-1:0] i_adc_data,
   // Host command
   input  wire logic                     i_cmd_valid,
   input  wire scan_pkg::host_cmd_t      i_cmd,
   input  wire logic [scan_pkg::CH_W-1:0] i_cmd_ch,
   input  wire scan_pkg::sensor_kind_t   i_cmd_kind,
   input  wire logic [scan_pkg::DATA_W-1:0] i_cmd_hi,
   input  wire logic [scan_pkg::DATA_W-1:0] i_cmd_lo,
   input  wire logic                     i_cmd_arm,
   input  wire logic                     i_alarm_ack,
   // Host answer
   input  wire logic                     i_rsp_ready,
   output logic                          o_rsp_valid,
   output logic [scan_pkg::CH_W-1:0]     o_rsp_ch,
   output logic [scan_pkg::DATA_W-1:0]   o_rsp_data,
   output logic                          o_rsp_last,
   output logic                          o_cmd_busy,
   // Analog front end
   output logic [scan_pkg::CH_W-1:0]     o_sense_mux,
   output logic [scan_pkg::CH_W-1:0]     o_exc_mux,
   output logic                          o_ref_sel,
   output scan_pkg::exc_src_t            o_exc_src,
   output logic                          o_exc_on,
   output logic                          o_adc_start,
   output logic                          o_afe_reset,
   // Status
   output logic                          o_alarm
);
   import scan_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum {SETTLE, DIGITIZE, RECOVER, PICK} phase_t;
   typedef enum {CIDLE, CONE, CALL, CWAIT} cmd_st_t;

   typedef struct packed
   {
      logic [1:0]                     adc_done_s;
      logic [1:0]                     cmd_v_s;
      logic [1:0]                     ack_s;
      logic [2:0]                     phase;
      logic [CNT_W-1:0]               cnt;
      logic [CH_W-1:0]                ch;
      logic                           ref_now;
      logic [4:0]                     since_ref;
      logic [NUM_CH-1:0][2:0]         kind;
      logic [NUM_CH-1:0][DATA_W-1:0]  hi_lim;
      logic [NUM_CH-1:0][DATA_W-1:0]  lo_lim;
      logic [NUM_CH-1:0]              armed;
      logic [NUM_CH-1:0][DATA_W-1:0]  filt;
      logic [DATA_W-1:0]              ref_val;
      logic [2:0]                     proc_stage;
      logic [CH_W-1:0]                proc_ch;
      logic [DATA_W-1:0]              proc_val;
      logic                           wr_en;
      logic                           alarm;
      logic [1:0]                     cst;
      logic [CNT_W-1:0]               rsp_cnt;
      logic [CH_W-1:0]                rsp_ch;
      logic                           rsp_all;
      logic                           rsp_valid;
      logic [CH_W-1:0]                rsp_ch_o;
      logic [DATA_W-1:0]              rsp_data;
      logic                           rsp_last;
      logic                           adc_start;
      logic                           exc_on;
      logic [1:0]                     exc_src;
   } seq_t;

   seq_t s_q;
   seq_t s_d;
   result_if rbus ();

   result_ram u_ram
   (
      .i_clk_sys (i_clk_sys),
      .bus       (rbus.mem)
   );

   // Next enabled channel after the given one, wrapping to the lowest.
   function automatic logic [CH_W-1:0] next_ch
      (input logic [CH_W-1:0] cur, input logic [NUM_CH-1:0][2:0] k);
      logic [CH_W-1:0] c;
      logic            found;
      c     = cur;
      found = 1'b0;
      next_ch = cur;
      for (int i = 1; i <= NUM_CH; i++)
      begin
         c = CH_W'(cur + CH_W'(i));
         if (!found && k[c] != 3'(KIND_DISABLED))
         begin
            next_ch = c;
            found   = 1'b1;
         end
      end
   endfunction

   function automatic logic [1:0] exc_for(input logic [2:0] k);
      if (k == 3'(KIND_GAGE))
         exc_for = 2'(EXC_VOLT10);
      else if (k == 3'(KIND_RTD) || k == 3'(KIND_RES_LOW))
         exc_for = 2'(EXC_CURRENT);
      else if (k == 3'(KIND_RES_HIGH))
         exc_for = 2'(EXC_SERIES5);
      else
         exc_for = 2'(EXC_NONE);
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic            paused;
   logic            any_on;
   logic [DATA_W-1:0] norm;
   logic [DATA_W-1:0] scaled;
   logic            hi_v;
   logic            lo_v;

   always_comb
   begin
      s_d = s_q;
      s_d.adc_done_s = {s_q.adc_done_s[0], i_adc_done};
      s_d.cmd_v_s    = {s_q.cmd_v_s[0], i_cmd_valid};
      s_d.ack_s      = {s_q.ack_s[0], i_alarm_ack};
      s_d.adc_start  = 1'b0;
      s_d.wr_en      = 1'b0;
      any_on    = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         any_on = any_on | (s_q.kind[i] != 3'(KIND_DISABLED));
      end
      paused = (s_q.cst != 2'(CIDLE)) || s_q.cmd_v_s[1];
      norm   = DATA_W'(s_q.proc_val - s_q.ref_val);
      scaled = norm;
      if (s_q.kind[s_q.proc_ch] == 3'(KIND_GAGE))
      begin
         scaled = {norm[DATA_W-1], norm[DATA_W-1:1]};
      end
      hi_v = $signed(s_q.filt[s_q.proc_ch]) > $signed(s_q.hi_lim[s_q.proc_ch]);
      lo_v = $signed(s_q.filt[s_q.proc_ch]) < $signed(s_q.lo_lim[s_q.proc_ch]);

      // Host commands take priority; scanning freezes while served.
      case (cmd_st_t'(s_q.cst))
         CIDLE:
         begin
            if (s_q.cmd_v_s[1])
            begin
               s_d.rsp_cnt = '0;
               s_d.rsp_ch  = i_cmd_ch;
               if (i_cmd == READ_ONE_CHANNEL_CMD)
                  s_d.cst = 2'(CONE);
               else if (i_cmd == READ_EVERY_CHANNEL_CMD)
               begin
                  s_d.cst    = 2'(CALL);
                  s_d.rsp_ch = '0;
               end
               else
               begin
                  if (i_cmd == DECLARE_SENSOR_KIND_CMD)
                  begin
                     s_d.kind[i_cmd_ch]   = 3'(i_cmd_kind);
                     s_d.hi_lim[i_cmd_ch] = i_cmd_hi;
                     s_d.lo_lim[i_cmd_ch] = i_cmd_lo;
                     s_d.armed[i_cmd_ch]  = i_cmd_arm;
                  end
                  s_d.cst = 2'(CWAIT);
               end
            end
         end
         CONE, CALL:
         begin
            s_d.rsp_cnt = CNT_W'(s_q.rsp_cnt + 1'b1);
            if (!s_q.rsp_valid || i_rsp_ready)
            begin
               s_d.rsp_valid = 1'b0;
               if (s_q.rsp_valid && s_q.rsp_last)
                  s_d.cst = 2'(CWAIT);
               else if (s_q.rsp_cnt >= 24'd2 && !s_q.rsp_valid)
               begin
                  s_d.rsp_valid = 1'b1;
                  s_d.rsp_ch_o  = s_q.rsp_ch;
                  s_d.rsp_data  = rbus.rd_data;
                  s_d.rsp_last  = (s_q.cst == 2'(CONE))
                                  || (s_q.rsp_ch == CH_W'(NUM_CH - 1));
                  s_d.rsp_ch    = CH_W'(s_q.rsp_ch + 1'b1);
                  s_d.rsp_cnt   = '0;
               end
            end
         end
         default:
         begin
            if (!s_q.cmd_v_s[1])
               s_d.cst = 2'(CIDLE);
         end
      endcase

      // Slot phases.
      if (!paused && any_on)
      begin
         s_d.cnt = CNT_W'(s_q.cnt - 1'b1);
         case (phase_t'(s_q.phase))
            PICK:
            begin
               s_d.ref_now = (s_q.since_ref == 5'(REF_PERIOD)) && !s_q.ref_now;
               s_d.since_ref = s_d.ref_now ? 5'd0
                               : 5'(s_q.since_ref + 1'b1);
               if (!s_d.ref_now)
                  s_d.ch = next_ch(s_q.ch, s_q.kind);
               s_d.exc_src = s_d.ref_now ? 2'(EXC_NONE)
                             : exc_for(s_q.kind[s_d.ch]);
               s_d.exc_on  = s_d.exc_src != 2'(EXC_NONE);
               s_d.cnt     = to_cnt(SETTLE_CYCLES);
               s_d.phase   = 3'(SETTLE);
            end
            SETTLE:
            begin
               if (s_q.cnt == '0)
               begin
                  s_d.adc_start = 1'b1;
                  s_d.cnt   = i_high_speed ? to_cnt(CONV_HS_CYCLES)
                              : to_cnt(CONV_CYCLES);
                  s_d.phase = 3'(DIGITIZE);
               end
            end
            DIGITIZE:
            begin
               if (s_q.adc_done_s[1] || s_q.cnt == '0)
               begin
                  if (s_q.ref_now)
                     s_d.ref_val = i_adc_data;
                  else
                  begin
                     s_d.proc_ch    = s_q.ch;
                     s_d.proc_val   = i_adc_data;
                     s_d.proc_stage = 3'd1;
                  end
                  s_d.cnt   = to_cnt(RECOVER_CYCLES);
                  s_d.phase = 3'(RECOVER);
               end
            end
            default:
            begin
               if (s_q.cnt == '0)
               begin
                  s_d.exc_on = 1'b0;
                  s_d.phase  = 3'(PICK);
               end
            end
         endcase
      end

      // Processing runs beside the recover phase.
      case (s_q.proc_stage)
         3'd1:
         begin
            s_d.filt[s_q.proc_ch] = DATA_W'(($signed(s_q.filt[s_q.proc_ch])
               + $signed(scaled)) >>> 1);
            s_d.proc_stage = 3'd2;
         end
         3'd2:
         begin
            if (s_q.armed[s_q.proc_ch] && (hi_v || lo_v))
            begin
               s_d.armed[s_q.proc_ch] = 1'b0;
               s_d.alarm = 1'b1;
               if (hi_v)
                  s_d.hi_lim[s_q.proc_ch] = HI_OFF;
               if (lo_v)
                  s_d.lo_lim[s_q.proc_ch] = LO_OFF;
            end
            s_d.proc_stage = 3'd3;
         end
         3'd3:
         begin
            s_d.wr_en = 1'b1;
            s_d.proc_stage = 3'd0;
         end
         default:
         begin
         end
      endcase

      // A fresh violation wins over the acknowledge.
      if (s_q.ack_s[1] && !(s_q.proc_stage == 3'd2
          && s_q.armed[s_q.proc_ch] && (hi_v || lo_v)))
         s_d.alarm = 1'b0;

      if (i_rst)
      begin
         s_d = '0;
         s_d.phase = 3'(PICK);
         s_d.ch    = CH_W'(NUM_CH - 1);
         for (int i = 0; i < NUM_CH; i++)
         begin
            s_d.hi_lim[i] = HI_OFF;
            s_d.lo_lim[i] = LO_OFF;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      s_q <= s_d;
   end

   assign rbus.wr_en   = s_q.wr_en;
   assign rbus.wr_addr = s_q.proc_ch;
   assign rbus.wr_data = s_q.filt[s_q.proc_ch];
   assign rbus.rd_addr = s_q.rsp_ch;

   assign o_rsp_valid = s_q.rsp_valid;
   assign o_rsp_ch    = s_q.rsp_ch_o;
   assign o_rsp_data  = s_q.rsp_data;
   assign o_rsp_last  = s_q.rsp_last;
   assign o_cmd_busy  = s_q.cst != 2'(CIDLE);
   assign o_sense_mux = s_q.ch;
   assign o_exc_mux   = s_q.ch;
   assign o_ref_sel   = s_q.ref_now;
   assign o_exc_src   = exc_src_t'(s_q.exc_src);
   assign o_exc_on    = s_q.exc_on;
   assign o_adc_start = s_q.adc_start;
   assign o_afe_reset = s_q.phase == 3'(RECOVER);
   assign o_alarm     = s_q.alarm;
endmodule

// ---- hw/scan_pkg.sv ----
// Constants and types shared by the scan sequencer and its result memory.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package scan_pkg;
   localparam int          NUM_CH       = 8;
   localparam int          CH_W         = 3;
   localparam int          DATA_W       = 16;
   localparam int          CLK_MHZ      = 50;
   // Phase times in microseconds.
   localparam int          SETTLE_US    = 2000;
   localparam int          CONV_US      = 16700;
   localparam int          CONV_HS_US   = 4000;
   localparam int          RECOVER_US   = 1000;
   localparam int          SLOT_MAX_US  = 22000;
   localparam int          ONE_RSP_US   = 100;
   localparam int          ALL_RSP_US   = 130;
   localparam int          SETTLE_CYC   = SETTLE_US * CLK_MHZ;
   localparam int          CONV_CYC     = CONV_US * CLK_MHZ;
   localparam int          CONV_HS_CYC  = CONV_HS_US * CLK_MHZ;
   localparam int          RECOVER_CYC  = RECOVER_US * CLK_MHZ;
   localparam int          SLOT_MAX_CYC = SLOT_MAX_US * CLK_MHZ;
   localparam int          ONE_RSP_CYC  = ONE_RSP_US * CLK_MHZ;
   localparam int          ALL_RSP_CYC  = ALL_RSP_US * CLK_MHZ;
   localparam int          CNT_W        = 24;
   localparam int          REF_PERIOD   = 16;
   localparam logic [DATA_W-1:0] HI_OFF = 16'h7FFF;
   localparam logic [DATA_W-1:0] LO_OFF = 16'h8000;
   localparam logic [CH_W:0] REF_TAG    = 4'h8;

   typedef enum logic [2:0]
   {
      KIND_DISABLED,
      KIND_VOLTAGE,
      KIND_THERMOCOUPLE,
      KIND_GAGE,
      KIND_RTD,
      KIND_RES_LOW,
      KIND_RES_HIGH
   } sensor_kind_t;

   typedef enum logic [1:0]
   {
      EXC_NONE,
      EXC_VOLT10,
      EXC_CURRENT,
      EXC_SERIES5
   } exc_src_t;

   typedef enum logic [1:0]
   {
      CMD_NONE,
      READ_ONE_CHANNEL_CMD,
      READ_EVERY_CHANNEL_CMD,
      DECLARE_SENSOR_KIND_CMD
   } host_cmd_t;

   function automatic logic [CNT_W-1:0] to_cnt(input int cyc);
      to_cnt = CNT_W'(cyc - 1);
   endfunction
endpackage

// ---- hw/result_if.sv ----
// Write and read channel between sequencer and result memory.
// Assumes both ends share i_clk_sys.
`timescale 1ns/1ps
interface result_if;
   import scan_pkg::*;
   logic              wr_en;
   logic [CH_W-1:0]   wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [CH_W-1:0]   rd_addr;
   logic [DATA_W-1:0] rd_data;
   modport seq (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface

// ---- hw/result_ram.sv ----
// Dual-port store of finished channel values, registered read data.
// Assumes writes and reads on the same clock.
`timescale 1ns/1ps
module result_ram
   import scan_pkg::*;
(
   // Clock
   input  wire logic  i_clk_sys,
   // Ports
   result_if.mem      bus
);
   typedef struct packed
   {
      logic [NUM_CH-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0]             rd;
   } ram_t;
   ram_t s_q;
   ram_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (bus.wr_en)
      begin
         s_d.mem[bus.wr_addr] = bus.wr_data;
      end
      s_d.rd = s_q.mem[bus.rd_addr];
   end

   always_ff @(posedge i_clk_sys)
   begin
      s_q <= s_d;
   end

   assign bus.rd_data = s_q.rd;
endmodule

// ---- test/scan_props.sv ----
// Checker on the sequencer's top ports, bound below.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module scan_props
   import scan_pkg::*;
#(
   parameter int SETTLE_CYCLES  = 10,
   parameter int RECOVER_CYCLES = 10
)
(
   // Clock, reset, host inputs
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic              i_cmd_valid,
   input  wire logic              i_alarm_ack,
   input  wire logic              i_rsp_ready,
   // Watched outputs
   input  wire logic              o_rsp_valid,
   input  wire logic [CH_W-1:0]   o_rsp_ch,
   input  wire logic [DATA_W-1:0] o_rsp_data,
   input  wire logic              o_cmd_busy,
   input  wire logic [CH_W-1:0]   o_sense_mux,
   input  wire logic [CH_W-1:0]   o_exc_mux,
   input  wire exc_src_t          o_exc_src,
   input  wire logic              o_exc_on,
   input  wire logic              o_adc_start,
   input  wire logic              o_afe_reset,
   input  wire logic              o_ref_sel,
   input  wire logic              o_alarm
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ****************
   // Phase counters
   // ****************
   logic [15:0] set_q = '0;
   logic [15:0] rec_q = '0;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || o_afe_reset || o_adc_start)
         set_q <= '0;
      else if (set_q != 16'hFFFF)
         set_q <= set_q + 16'h0001;
      if (i_rst || !o_afe_reset)
         rec_q <= '0;
      else
         rec_q <= rec_q + 16'h0001;
   end
   property p_start_pulse;
      o_adc_start |=> !o_adc_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start");
   property p_settle;
      o_adc_start |-> set_q >= SETTLE_CYCLES;
   endproperty
   a_settle: assert property (p_settle) else $error("settle");
   property p_mux_pair;
      o_adc_start |-> (o_sense_mux == o_exc_mux) && $stable(o_sense_mux);
   endproperty
   a_mux_pair: assert property (p_mux_pair) else $error("mux");
   property p_exc_src;
      o_exc_on |-> o_exc_src != EXC_NONE;
   endproperty
   a_exc_src: assert property (p_exc_src) else $error("exc src");
   property p_exc_slot;
      $fell(o_exc_on) |-> $past(o_afe_reset) || $past(o_afe_reset, 2);
   endproperty
   a_exc_slot: assert property (p_exc_slot) else $error("exc cut");
   property p_recover;
      $fell(o_afe_reset) |-> rec_q >= RECOVER_CYCLES;
   endproperty
   a_recover: assert property (p_recover) else $error("recover");
   property p_paused;
      o_cmd_busy |-> !o_adc_start;
   endproperty
   a_paused: assert property (p_paused) else $error("paused");
   property p_taken;
      $rose(i_cmd_valid) && !o_cmd_busy |-> ##[1:5] o_cmd_busy;
   endproperty
   a_taken: assert property (p_taken) else $error("cmd taken");
   property p_rsp_hold;
      o_rsp_valid && !i_rsp_ready |=>
         o_rsp_valid && $stable(o_rsp_data) && $stable(o_rsp_ch);
   endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("rsp hold");
   property p_alarm_clear;
      $fell(o_alarm) |-> $past(i_alarm_ack) || $past(i_alarm_ack, 2) ||
         $past(i_alarm_ack, 3) || $past(i_alarm_ack, 4);
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm lost");
   c_start: cover property (o_adc_start);
   c_last: cover property (o_rsp_valid && i_rsp_ready && o_rsp_ch == 3'h7);
   c_alarm: cover property ($rose(o_alarm));
   c_ref: cover property (o_ref_sel);
endmodule

bind sensor_scan_sequencer scan_props #(
   .SETTLE_CYCLES  (SETTLE_CYCLES),
   .RECOVER_CYCLES (RECOVER_CYCLES)
) scan_props_inst (.i_clk_sys, .i_rst, .i_cmd_valid, .i_alarm_ack,
   .i_rsp_ready, .o_rsp_valid, .o_rsp_ch, .o_rsp_data, .o_cmd_busy,
   .o_sense_mux, .o_exc_mux, .o_exc_src, .o_exc_on, .o_adc_start,
   .o_afe_reset, .o_ref_sel, .o_alarm);

// ---- test/host_model.sv ----
// Host model: accepts answer words, promptly or slowly, and logs them.
// Assumes a valid/ready answer channel on the system clock.
`timescale 1ns/1ps
module host_model
   import scan_pkg::*;
(
   // Clock and reset
   input  wire logic            i_clk_sys,
   input  wire logic            i_rst,
   // Control and answers
   input  wire logic            i_stall,
   input  wire logic            i_rsp_valid,
   input  wire logic [CH_W-1:0] i_rsp_ch,
   input  wire logic            i_rsp_last,
   output logic                 o_rsp_ready = 1'b0,
   output logic [7:0]           o_words = 8'h00
);
   logic [CH_W-1:0] ch_q [8];
   logic [7:0]      last_q;
   logic [1:0]      tick_q = 2'h0;
   always_ff @(posedge i_clk_sys)
   begin
      tick_q <= tick_q + 2'h1;
      // A slow host takes one word in four cycles.
      o_rsp_ready <= !i_stall || (tick_q == 2'h3);
      if (i_rst)
         o_words <= 8'h00;
      else if (i_rsp_valid && o_rsp_ready)
      begin
         ch_q[o_words[2:0]]   <= i_rsp_ch;
         last_q[o_words[2:0]] <= i_rsp_last;
         o_words              <= o_words + 8'h01;
      end
   end
endmodule

// ---- test/sensor_scan_sequencer_tb.sv ----
// Self-checking bench for the scan sequencer.
// Assumes short phase counts via the design's parameters.
`timescale 1ns/1ps
module sensor_scan_sequencer_tb;
   import scan_pkg::*;
   localparam int SET_N = 10, CONV_N = 40, HS_N = 20, REC_N = 10;
   logic clk = 1'b0, rst = 1'b1, hs = 1'b0, adc_done = 1'b0, adc_hold = 1'b0;
   logic cmd_valid = 1'b0, cmd_arm = 1'b0, alarm_ack = 1'b0, stall = 1'b0;
   logic [DATA_W-1:0] adc_data = 16'h1000, cmd_hi = '0, cmd_lo = '0;
   host_cmd_t cmd = CMD_NONE;
   sensor_kind_t cmd_kind = KIND_DISABLED;
   logic [CH_W-1:0] cmd_ch = '0, rsp_ch, sense_mux, exc_mux;
   logic rsp_ready, rsp_valid, rsp_last, busy, exc_on, adc_start;
   logic afe_reset, ref_sel, alarm;
   logic [DATA_W-1:0] rsp_data;
   exc_src_t exc_src;
   logic [7:0] words;
   int miscompares = 0, check_count = 0, adc_cnt = 0, starts = 0;
   always #10 clk = ~clk;
   sensor_scan_sequencer #(.SETTLE_CYCLES(SET_N), .CONV_CYCLES(CONV_N),
      .CONV_HS_CYCLES(HS_N), .RECOVER_CYCLES(REC_N))
   sensor_scan_sequencer_inst (.i_clk_sys(clk), .i_rst(rst),
      .i_high_speed(hs), .i_adc_done(adc_done), .i_adc_data(adc_data),
      .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_ch(cmd_ch),
      .i_cmd_kind(cmd_kind), .i_cmd_hi(cmd_hi), .i_cmd_lo(cmd_lo),
      .i_cmd_arm(cmd_arm), .i_alarm_ack(alarm_ack),
      .i_rsp_ready(rsp_ready), .o_rsp_valid(rsp_valid), .o_rsp_ch(rsp_ch),
      .o_rsp_data(rsp_data), .o_rsp_last(rsp_last), .o_cmd_busy(busy),
      .o_sense_mux(sense_mux), .o_exc_mux(exc_mux), .o_ref_sel(ref_sel),
      .o_exc_src(exc_src), .o_exc_on(exc_on), .o_adc_start(adc_start),
      .o_afe_reset(afe_reset), .o_alarm(alarm));
   host_model host_model_inst (.i_clk_sys(clk), .i_rst(rst),
      .i_stall(stall), .i_rsp_valid(rsp_valid), .i_rsp_ch(rsp_ch),
      .i_rsp_last(rsp_last), .o_rsp_ready(rsp_ready), .o_words(words));
   // ****************
   // Converter stand-in
   // ****************
   // Done follows start by six cycles unless held off.
   always @(posedge clk)
   begin
      adc_cnt <= adc_start ? 5 : (adc_cnt > 0 ? adc_cnt - 1 : 0);
      starts <= starts + (adc_start ? 1 : 0);
      adc_done <= afe_reset ? 1'b0 : ((adc_cnt == 1 && !adc_hold) | adc_done);
   end
   // ****************
   // Shared tasks
   // ****************
   task report_and_stop;
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, seen);
         miscompares++;
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return adc_start;
         1: return afe_reset;
         2: return busy;
         3: return !busy;
         default: return alarm;
      endcase
   endfunction
   task wait_sig(input int s, input int lim, output int n);
      n = 0;
      while (sig(s) !== 1'b1)
      begin
         if (n >= lim)
         begin
            miscompares++;
            report_and_stop();
         end
         @(posedge clk);
         n++;
      end
   endtask
   task send_cmd(input host_cmd_t c, input logic [CH_W-1:0] ch,
                 input sensor_kind_t k, input logic [DATA_W-1:0] hi, lo,
                 input logic arm, input int nw);
      int n;
      logic [7:0] base;
      base = words;
      cmd <= c;
      cmd_ch <= ch;
      cmd_kind <= k;
      cmd_hi <= hi;
      cmd_lo <= lo;
      cmd_arm <= arm;
      cmd_valid <= 1'b1;
      wait_sig(2, 10, n);
      for (n = 0; 8'(words - base) != nw[7:0]; n++)
      begin
         if (n > ALL_RSP_CYC)
            wait_sig(3, 0, n);
         @(posedge clk);
      end
      check("rsp time", n <= (nw > 1 ? ALL_RSP_CYC : ONE_RSP_CYC), 1);
      cmd_valid <= 1'b0;
      wait_sig(3, 20, n);
      // Spacing keeps traffic from starving the scan.
      repeat (20) @(posedge clk);
   endtask
   task declare(input logic [CH_W-1:0] ch, input sensor_kind_t k,
                input logic [DATA_W-1:0] hi, input logic arm);
      send_cmd(DECLARE_SENSOR_KIND_CMD, ch, k, hi, LO_OFF, arm, 0);
   endtask
   // ****************
   // Scenarios
   // ****************
   task test_reset;
      int s;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("sense mux", sense_mux, 7);
      check("exc mux", exc_mux, 7);
      check("alarm", alarm, 0);
      check("exc on", exc_on, 0);
      check("rsp valid", rsp_valid, 0);
      s = starts;
      repeat (200) @(posedge clk);
      check("idle", starts, s);
   endtask
   task test_scan;
      int n, i;
      logic [CH_W-1:0] ech [5];
      exc_src_t es [5];
      ech = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h1};
      es = '{EXC_NONE, EXC_VOLT10, EXC_CURRENT, EXC_SERIES5, EXC_NONE};
      declare(1, KIND_VOLTAGE, HI_OFF, 0);
      declare(2, KIND_GAGE, HI_OFF, 0);
      declare(5, KIND_RTD, HI_OFF, 0);
      declare(6, KIND_RES_HIGH, HI_OFF, 0);
      for (i = 0; i < 8 && !(adc_start && sense_mux == 3'h1); i++)
      begin
         @(posedge clk);
         wait_sig(0, 400, n);
      end
      for (i = 0; i < 5; i++)
      begin
         if (i > 0)
            wait_sig(0, 400, n);
         check("sense mux", sense_mux, ech[i]);
         check("exc mux", exc_mux, ech[i]);
         check("exc src", exc_src, es[i]);
         check("exc on", exc_on, es[i] != EXC_NONE);
         wait_sig(1, CONV_N + 20, n);
         check("rec mux", sense_mux, ech[i]);
         check("rec exc", exc_on, es[i] != EXC_NONE);
      end
   endtask
   task test_speed;
      int n, m;
      int len [2];
      adc_hold <= 1'b1;
      for (m = 0; m < 2; m++)
      begin
         hs <= m[0];
         wait_sig(0, 400, n);
         @(posedge clk);
         wait_sig(0, 400, n);
         wait_sig(1, CONV_N + 20, len[m]);
      end
      check("hs cut", len[0] - len[1], CONV_N - HS_N);
      adc_hold <= 1'b0;
      hs <= 1'b0;
   endtask
   task test_reads;
      int i;
      logic [7:0] b;
      stall <= 1'b1;
      send_cmd(READ_ONE_CHANNEL_CMD, 5, KIND_DISABLED, 0, 0, 0, 1);
      check("one ch", host_model_inst.ch_q[3'(words - 1)], 5);
      stall <= 1'b0;
      b = words;
      send_cmd(READ_EVERY_CHANNEL_CMD, 0, KIND_DISABLED, 0, 0, 0, 8);
      for (i = 0; i < 8; i++)
      begin
         check("all ch", host_model_inst.ch_q[3'(b + i)], i);
         check("all last", host_model_inst.last_q[3'(b + i)], i == 7);
      end
   endtask
   task test_alarm;
      int n;
      adc_data <= 16'h4000;
      declare(2, KIND_GAGE, 16'h0010, 1);
      wait_sig(4, 3000, n);
      alarm_ack <= 1'b1;
      repeat (6) @(posedge clk);
      alarm_ack <= 1'b0;
      repeat (6) @(posedge clk);
      check("acked", alarm, 0);
      repeat (600) @(posedge clk);
      check("rearm", alarm, 0);
   endtask
   initial
   begin
      test_reset;
      test_scan;
      test_speed;
      test_reads;
      test_alarm;
      test_reset;
      report_and_stop;
   end
endmodule
